// *** bench/pbsc_monitor.sv ***
// Port-level assertions for the configuration bank
module pbsc_monitor #(
  parameter bit SOFT_CORE = 1'b0
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Configuration memory
  input wire logic        cfg_rd_req,
  input wire logic [7:0]  cfg_rd_word,
  input wire logic        cfg_rd_valid,
  input wire logic        cfg_loaded,
  // Pins and events
  input wire logic [1:0]  sync_level,
  input wire logic [1:0]  shared_pin_in,
  input wire logic [1:0]  latch_level,
  input wire logic [1:0]  application_event_request_sync
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Load steps: first word taken, second word asked for, second word taken
  sequence s_main_taken;
    cfg_rd_req && cfg_rd_valid && cfg_rd_word == 8'h01;
  endsequence
  sequence s_ext_request;
    !cfg_rd_req ##1 (cfg_rd_req && cfg_rd_word == 8'h03);
  endsequence
  sequence s_ext_taken;
    cfg_rd_req && cfg_rd_valid && cfg_rd_word == 8'h03;
  endsequence
  a_okay_only: assert property (hresp == 1'b0) else $error("bad response");
  a_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state");
  // Writes and idle cycles must leave the read bus at zero
  a_rdata_idle: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0) else $error("stray read data");
  a_req_holds: assert property (
    cfg_rd_req && !cfg_rd_valid |=> cfg_rd_req && $stable(cfg_rd_word)) else $error("request dropped");
  a_word_order: assert property (s_main_taken |=> s_ext_request) else $error("word order");
  a_loaded_soon: assert property (s_ext_taken |-> ##[1:2] cfg_loaded) else $error("load flag late");
  a_not_early: assert property (cfg_rd_req |-> !cfg_loaded) else $error("loaded too early");
  // An event bit may only follow a raised sync signal
  a_event_map: assert property (
    (application_event_request_sync & ~$past(sync_level)) == 2'b00) else $error("event without sync");
  a_latch_input: assert property (
    SOFT_CORE || (latch_level & ~$past(shared_pin_in)) == 2'b00) else $error("latch without pin");
endmodule // pbsc_monitor

bind pbsc_top pbsc_monitor #(.SOFT_CORE(SOFT_CORE)) pbsc_monitor_i (.clk, .rst_n, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .cfg_rd_req, .cfg_rd_word, .cfg_rd_valid, .cfg_loaded,
  .sync_level, .shared_pin_in, .latch_level, .application_event_request_sync);

// *** bench/pdi_bridge_sync_config_test.sv ***
// Self-checking bench for the configuration bank
module pdi_bridge_sync_config_test
  import pbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_MAIN = {18'h0, PBSC_IDX_MAIN_CFG, 2'b00};
  localparam logic [31:0] A_SYNC = {18'h0, PBSC_IDX_SYNC_CFG, 2'b00};
  localparam logic [31:0] A_EXT  = {18'h0, PBSC_IDX_EXT_CFG, 2'b00};
  localparam logic [31:0] A_STAT = {18'h0, PBSC_IDX_LOAD_STAT, 2'b00};
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cfg_rd_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_q;
  logic [1:0]  htrans = 2'h0, sync_level = 2'h0, shared_pin_in = 2'h0, timestamp_in = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] cfg_rd_data = 16'h0;
  logic        hreadyout, hresp, cfg_rd_req, cfg_loaded, bridge_phy_mii, obus_clk_async, axi_subtype_valid, rdy_q;
  logic [7:0]  cfg_rd_word;
  logic [1:0]  bridge_loop_ctrl, axi_subtype, sync_pulse_out_o, sync_pulse_out_oe, latch_level;
  logic [1:0]  application_event_request_sync;
  logic [4:0]  obus_clk_mult;
  logic [2:0]  obus_type, prefetch_cycles;
  int          err_count = 0, n_tests = 0, cyc = 0;

  pbsc_top pbsc_top_i (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata(), .cfg_rd_req, .cfg_rd_word, .cfg_rd_valid, .cfg_rd_data, .cfg_loaded,
    .bridge_phy_mii, .bridge_loop_ctrl, .obus_clk_async, .obus_clk_mult, .obus_type, .prefetch_cycles,
    .axi_subtype_valid, .axi_subtype, .sync_level, .shared_pin_in, .timestamp_in, .sync_pulse_out_o,
    .sync_pulse_out_oe, .latch_level, .application_event_request_sync);

  always #20 clk = ~clk;
  // Capture the pre-edge bus answer so the task never races the slave's flops
  always @(posedge clk) begin
    rdy_q <= hreadyout;
    rd_q <= pbsc_top_i.hrdata;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // One single AHB-Lite transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do tick(); while (rdy_q !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do tick(); while (rdy_q !== 1'b1);
    r = rd_q;
    // Select stays up between transfers; IDLE htrans keeps the slave quiet
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // Answer one configuration word request after a chosen delay
  task automatic serve(input logic [7:0] word, input logic [15:0] d, input int lag);
    while (!(cfg_rd_req === 1'b1 && cfg_rd_word === word)) tick();
    repeat (lag) tick();
    cfg_rd_valid <= 1'b1;
    cfg_rd_data <= d;
    tick();
    cfg_rd_valid <= 1'b0;
    cfg_rd_data <= ~d;
  endtask

  // Expected {oe, out} of a pin for a driver code, direction and sync level
  function automatic logic [1:0] drv(input logic [1:0] c, input logic dir, input logic s);
    if (!dir) return 2'b00;
    case (c)
      2'b00: return {1'b1, ~s};
      2'b01: return {s, 1'b0};
      2'b10: return {1'b1, s};
      default: return {s, 1'b1};
    endcase
  endfunction

  task automatic run(input logic [7:0] m, input logic [7:0] sy);
    logic [31:0] r;
    sync_level <= 2'b00;
    rst_n <= 1'b0;
    repeat (8) tick();
    rst_n <= 1'b1;
    tick();
    rd(A_MAIN, 32'h0);
    chk(bridge_loop_ctrl, 2'h3);
    serve(PBSC_WORD_MAIN, {sy, m}, 3);
    serve(PBSC_WORD_EXT, 16'h0702, 0);
    repeat (3) tick();
    rd(A_STAT, 32'h1);
    rd(A_MAIN, {24'h0, m});
    rd(A_SYNC, {24'h0, sy});
    rd(A_EXT, 32'h0);
    ahb(1'b1, A_SYNC, 32'hFFFFFFFF, r);
    rd(A_SYNC, {24'h0, sy});
    rd(32'h0000_0600, 32'h0);
    chk(bridge_phy_mii, m[0]);
    chk(bridge_loop_ctrl, m[1] ? 2'h0 : 2'h3);
    // Bridge build: bus decode outputs stay at zero, sub-type mirrors ext[9:8]
    chk({obus_clk_async, obus_clk_mult, obus_type, prefetch_cycles, axi_subtype_valid}, 32'h0);
    chk(axi_subtype, 2'h3);
    // Both sync levels, pin levels following them
    for (int s = 0; s < 2; s++) begin
      sync_level <= {2{s[0]}};
      shared_pin_in <= {2{s[0]}};
      tick();
      tick();
      chk({sync_pulse_out_oe[0], sync_pulse_out_o[0]}, drv(sy[1:0], sy[2], s[0]));
      chk({sync_pulse_out_oe[1], sync_pulse_out_o[1]}, drv(sy[5:4], sy[6], s[0]));
      chk(application_event_request_sync, {sy[7], sy[3]} & {2{s[0]}});
      chk(latch_level, ~{sy[6], sy[2]} & {2{s[0]}});
    end
  endtask

  // Three loads cover every driver code, both directions and both mappings
  initial begin
    run(8'h02, 8'hFD);
    run(8'h01, 8'h06);
    run(8'h00, 8'h4C);
    report_and_stop();
  end
endmodule // pdi_bridge_sync_config_test

// *** common/pbsc_pin_if.sv ***
// Signals between the bank and one sync/latch pin driver
interface pbsc_pin_if;
  logic [1:0] drv_code;
  logic       dir_out;
  logic       map_en;
  logic       sync_level;
  logic       pin_in;
  logic       latch_sep;
  logic       pin_out;
  logic       pin_oe;
  logic       latch_level;
  logic       event_req;
  modport bank (output drv_code, output dir_out, output map_en, output sync_level,
                output pin_in, output latch_sep,
                input pin_out, input pin_oe, input latch_level, input event_req);
  modport pin  (input drv_code, input dir_out, input map_en, input sync_level,
                input pin_in, input latch_sep,
                output pin_out, output pin_oe, output latch_level, output event_req);
endinterface

// *** common/pbsc_pkg.sv ***
// Constants and types for the bridge/process-data/sync configuration bank
package pbsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] PBSC_IDX_MAIN_CFG   = 12'h150;
  localparam logic [11:0] PBSC_IDX_SYNC_CFG   = 12'h151;
  localparam logic [11:0] PBSC_IDX_EXT_CFG    = 12'h152;
  localparam logic [11:0] PBSC_IDX_LOAD_STAT  = 12'h154;
  // Configuration memory words
  localparam logic [7:0]  PBSC_WORD_MAIN      = 8'h01;
  localparam logic [7:0]  PBSC_WORD_EXT       = 8'h03;
  // Bridge field positions
  localparam int          PBSC_BR_PHY_BIT     = 0;
  localparam int          PBSC_BR_INIT_BIT    = 1;
  localparam logic [1:0]  PBSC_LOOP_CLOSED    = 2'h3;
  localparam logic [1:0]  PBSC_LOOP_AUTO      = 2'h0;
  // On-chip bus fields
  localparam int          PBSC_OB_CLK_LSB     = 0;
  localparam int          PBSC_OB_TYPE_LSB    = 5;
  localparam logic [2:0]  PBSC_OB_TYPE_AXI    = 3'h1;
  localparam int          PBSC_PF_LSB         = 0;
  localparam int          PBSC_AXI_LSB        = 8;
  localparam real         PBSC_BASE_MHZ       = 25.0;
  // Sync/latch fields per pin: driver lsb, direction, map enable
  localparam int          PBSC_SYNC_STRIDE    = 4;
  localparam int          PBSC_SYNC_DIR_OFS   = 2;
  localparam int          PBSC_SYNC_MAP_OFS   = 3;
  // Reset values
  localparam logic [7:0]  PBSC_MAIN_RST       = 8'h00;
  localparam logic [7:0]  PBSC_SYNC_RST_HARD  = 8'h00;
  localparam logic [7:0]  PBSC_SYNC_RST_SOFT  = 8'h66;
  localparam logic [15:0] PBSC_EXT_RST        = 16'h0000;
  // Driver codes
  typedef enum logic [1:0] {
    PBSC_DRV_PP_LOW  = 2'b00,
    PBSC_DRV_OD_LOW  = 2'b01,
    PBSC_DRV_PP_HIGH = 2'b10,
    PBSC_DRV_OS_HIGH = 2'b11
  } pbsc_drv_t;
  // Load sequencer states
  typedef enum logic [2:0] {
    PBSC_LD_REQ_MAIN = 3'b000,
    PBSC_LD_REQ_EXT  = 3'b001,
    PBSC_LD_DONE     = 3'b010
  } pbsc_ld_t;
endpackage

// *** logic/pbsc_pin.sv ***
// One sync output / latch input pin with driver style and event mapping
module pbsc_pin
  import pbsc_pkg::*;
#(
  parameter bit SOFT_CORE = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bank side
  pbsc_pin_if.pin   pif
);
  logic out_ff, nxt_out;
  logic oe_ff, nxt_oe;
  logic latch_ff, nxt_latch;
  logic evt_ff, nxt_evt;
  logic drive_en;

  // Soft core drives its sync pin regardless of the direction bit
  assign drive_en = SOFT_CORE ? 1'b1 : pif.dir_out;

  // Driver style decode; open styles release the pin when inactive
  always_comb begin
    nxt_out = 1'b0;
    nxt_oe  = 1'b0;
    if (drive_en) begin
      case (pbsc_drv_t'(pif.drv_code))
        PBSC_DRV_PP_LOW: begin
          nxt_out = ~pif.sync_level;
          nxt_oe  = 1'b1;
        end
        PBSC_DRV_OD_LOW: begin
          nxt_out = 1'b0;
          nxt_oe  = pif.sync_level;
        end
        PBSC_DRV_PP_HIGH: begin
          nxt_out = pif.sync_level;
          nxt_oe  = 1'b1;
        end
        PBSC_DRV_OS_HIGH: begin
          nxt_out = 1'b1;
          nxt_oe  = pif.sync_level;
        end
        default: begin
          nxt_out = 1'b0;
          nxt_oe  = 1'b0;
        end
      endcase
    end
    // Latch from own pin on shared variant, separate input on soft core
    nxt_latch = SOFT_CORE ? pif.latch_sep : (~pif.dir_out & pif.pin_in);
    nxt_evt   = pif.map_en & pif.sync_level;
  end

  // Registered pin outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      latch_ff <= 1'b0;
      evt_ff   <= 1'b0;
    end else begin
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
      latch_ff <= nxt_latch;
      evt_ff   <= nxt_evt;
    end
  end

  assign pif.pin_out     = out_ff;
  assign pif.pin_oe      = oe_ff;
  assign pif.latch_level = latch_ff;
  assign pif.event_req   = evt_ff;
endmodule // pbsc_pin

// *** logic/pbsc_top.sv ***
// Read-only configuration bank loaded from configuration memory (set by parameters at reset on soft core), AHB-Lite slave
module pbsc_top
  import pbsc_pkg::*;
#(
  parameter bit         SOFT_CORE    = 1'b0,
  parameter bit         ONCHIP_BUS   = 1'b0,
  parameter logic [7:0] SOFT_MAIN    = 8'h00,
  parameter logic [1:0] SOFT_MAP     = 2'b00,
  parameter logic [15:0] SOFT_EXT    = 16'h0001
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Configuration memory read port
  output logic             cfg_rd_req,
  output logic [7:0]       cfg_rd_word,
  input  wire logic        cfg_rd_valid,
  input  wire logic [15:0] cfg_rd_data,
  // Decoded configuration
  output logic             cfg_loaded,
  output logic             bridge_phy_mii,
  output logic [1:0]       bridge_loop_ctrl,
  output logic             obus_clk_async,
  output logic [4:0]       obus_clk_mult,
  output logic [2:0]       obus_type,
  output logic [2:0]       prefetch_cycles,
  output logic             axi_subtype_valid,
  output logic [1:0]       axi_subtype,
  // Sync and latch pins
  input  wire logic [1:0]  sync_level,
  input  wire logic [1:0]  shared_pin_in,
  input  wire logic [1:0]  timestamp_in,
  output logic [1:0]       sync_pulse_out_o,
  output logic [1:0]       sync_pulse_out_oe,
  output logic [1:0]       latch_level,
  output logic [1:0]       application_event_request_sync
);
  // Elaboration guard: flags a SOFT_MAP value above 2'b11 as an error
  if (SOFT_MAP > 2'b11) begin : g_bad
    $error("pbsc_top: bad SOFT_MAP");
  end

  localparam logic [7:0] SYNC_RST = SOFT_CORE ? (PBSC_SYNC_RST_SOFT | {SOFT_MAP[1], 3'h0, SOFT_MAP[0], 3'h0})
                                              : PBSC_SYNC_RST_HARD;
  localparam logic [7:0]  MAIN_RST = SOFT_CORE ? SOFT_MAIN : PBSC_MAIN_RST;
  localparam logic [15:0] EXT_RST  = SOFT_CORE ? SOFT_EXT : PBSC_EXT_RST;
  localparam pbsc_ld_t    LD_RST   = SOFT_CORE ? PBSC_LD_DONE : PBSC_LD_REQ_MAIN;

  // Register state
  logic [7:0]  main_ff, nxt_main;
  logic [7:0]  sync_ff, nxt_sync;
  logic [15:0] ext_ff, nxt_ext;
  pbsc_ld_t    ld_ff, nxt_ld;
  logic        req_ff, nxt_req;
  logic [7:0]  word_ff, nxt_word;

  // Load sequencer: word 1 holds 0x150/0x151, word 3 holds 0x152
  always_comb begin
    nxt_main = main_ff;
    nxt_sync = sync_ff;
    nxt_ext  = ext_ff;
    nxt_ld   = ld_ff;
    nxt_req  = 1'b0;
    nxt_word = word_ff;
    case (ld_ff)
      PBSC_LD_REQ_MAIN: begin
        nxt_req  = 1'b1;
        nxt_word = PBSC_WORD_MAIN;
        if (req_ff && cfg_rd_valid) begin
          nxt_main = cfg_rd_data[7:0];
          nxt_sync = cfg_rd_data[15:8];
          nxt_ld   = PBSC_LD_REQ_EXT;
          nxt_req  = 1'b0;
        end
      end
      PBSC_LD_REQ_EXT: begin
        nxt_req  = 1'b1;
        nxt_word = PBSC_WORD_EXT;
        if (req_ff && cfg_rd_valid) begin
          nxt_ext = cfg_rd_data;
          nxt_ld  = PBSC_LD_DONE;
          nxt_req = 1'b0;
        end
      end
      PBSC_LD_DONE: begin
        nxt_req = 1'b0;
      end
      default: begin
        nxt_ld = PBSC_LD_DONE;
      end
    endcase
  end

  // Reset values stay until the sequencer replaces them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_ff <= MAIN_RST;
      sync_ff <= SYNC_RST;
      ext_ff  <= EXT_RST;
      ld_ff   <= LD_RST;
      req_ff  <= 1'b0;
      word_ff <= 8'h00;
    end else begin
      main_ff <= nxt_main;
      sync_ff <= nxt_sync;
      ext_ff  <= nxt_ext;
      ld_ff   <= nxt_ld;
      req_ff  <= nxt_req;
      word_ff <= nxt_word;
    end
  end

  assign cfg_rd_req  = req_ff;
  assign cfg_rd_word = word_ff;

  // Decode state
  logic       loaded_ff, nxt_loaded;
  logic       phy_ff, nxt_phy;
  logic [1:0] loop_ff, nxt_loop;
  logic       async_ff, nxt_async;
  logic [4:0] mult_ff, nxt_mult;
  logic [2:0] type_ff, nxt_type;
  logic [2:0] pf_ff, nxt_pf;
  logic       axv_ff, nxt_axv;
  logic [1:0] axs_ff, nxt_axs;

  // Field decode; the 0x150 byte means bridge or bus by build option, except bit 1, which sets bridge_loop_ctrl in both builds
  always_comb begin
    nxt_loaded = (ld_ff == PBSC_LD_DONE);
    nxt_phy    = ~ONCHIP_BUS & main_ff[PBSC_BR_PHY_BIT];
    nxt_loop   = main_ff[PBSC_BR_INIT_BIT] ? PBSC_LOOP_AUTO : PBSC_LOOP_CLOSED;
    nxt_mult   = main_ff[PBSC_OB_CLK_LSB +: 5];
    nxt_async  = (main_ff[PBSC_OB_CLK_LSB +: 5] == 5'h00);
    nxt_type   = main_ff[PBSC_OB_TYPE_LSB +: 3];
    case (ext_ff[PBSC_PF_LSB +: 2])
      2'h0:    nxt_pf = 3'h4;
      2'h1:    nxt_pf = 3'h1;
      2'h2:    nxt_pf = 3'h2;
      default: nxt_pf = 3'h0; // Reserved code gives zero
    endcase
    nxt_axs = ext_ff[PBSC_AXI_LSB +: 2];
    // Sub-type meaningful only for AXI and the three defined codes
    nxt_axv = ONCHIP_BUS && (nxt_type == PBSC_OB_TYPE_AXI) &&
              (ext_ff[PBSC_AXI_LSB +: 3] <= 3'h2);
    if (!ONCHIP_BUS) begin
      nxt_async = 1'b0;
      nxt_mult  = 5'h00;
      nxt_type  = 3'h0;
      nxt_pf    = 3'h0;
    end
  end

  // Decoded outputs registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_ff <= 1'b0;
      phy_ff    <= 1'b0;
      loop_ff   <= PBSC_LOOP_CLOSED;
      async_ff  <= 1'b0;
      mult_ff   <= 5'h00;
      type_ff   <= 3'h0;
      pf_ff     <= 3'h0;
      axv_ff    <= 1'b0;
      axs_ff    <= 2'h0;
    end else begin
      loaded_ff <= nxt_loaded;
      phy_ff    <= nxt_phy;
      loop_ff   <= nxt_loop;
      async_ff  <= nxt_async;
      mult_ff   <= nxt_mult;
      type_ff   <= nxt_type;
      pf_ff     <= nxt_pf;
      axv_ff    <= nxt_axv;
      axs_ff    <= nxt_axs;
    end
  end

  assign cfg_loaded        = loaded_ff;
  assign bridge_phy_mii    = phy_ff;
  assign bridge_loop_ctrl  = loop_ff;
  assign obus_clk_async    = async_ff;
  assign obus_clk_mult     = mult_ff;
  assign obus_type         = type_ff;
  assign prefetch_cycles   = pf_ff;
  assign axi_subtype_valid = axv_ff;
  assign axi_subtype       = axs_ff;

  // Sync/latch pins, one driver per pin
  for (genvar i = 0; i < 2; i++) begin : g_pin
    pbsc_pin_if pif ();
    assign pif.drv_code   = sync_ff[i*PBSC_SYNC_STRIDE +: 2];
    assign pif.dir_out    = sync_ff[i*PBSC_SYNC_STRIDE + PBSC_SYNC_DIR_OFS];
    assign pif.map_en     = sync_ff[i*PBSC_SYNC_STRIDE + PBSC_SYNC_MAP_OFS];
    assign pif.sync_level = sync_level[i];
    assign pif.pin_in     = shared_pin_in[i];
    assign pif.latch_sep  = timestamp_in[i];
    pbsc_pin #(.SOFT_CORE(SOFT_CORE)) u_pin (
      .clk   (clk),
      .rst_n (rst_n),
      .pif   (pif.pin)
    );
    assign sync_pulse_out_o[i]               = pif.pin_out;
    assign sync_pulse_out_oe[i]              = pif.pin_oe;
    assign latch_level[i]                    = pif.latch_level;
    assign application_event_request_sync[i] = pif.event_req;
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic [31:0] rdata_ff, nxt_rdata;
  logic        rd_take;
  logic [11:0] idx;

  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign idx     = haddr[13:2];

  // Writes are accepted and dropped; nothing here is writable
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_take) begin
      case (idx)
        PBSC_IDX_MAIN_CFG:  nxt_rdata = {24'h00_0000, main_ff};
        PBSC_IDX_SYNC_CFG:  nxt_rdata = {24'h00_0000, sync_ff};
        PBSC_IDX_EXT_CFG:   nxt_rdata = ONCHIP_BUS ? {16'h0000, ext_ff} : 32'h0000_0000;
        PBSC_IDX_LOAD_STAT: nxt_rdata = {31'h0000_0000, loaded_ff};
        default:            nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data registered into the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  logic hrdy_ff;
  logic hresp_ff;
  // Constant handshake outputs kept in flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdy_ff  <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hrdy_ff  <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hreadyout = hrdy_ff;
  assign hresp     = hresp_ff;
  assign hrdata    = rdata_ff;
endmodule // pbsc_top
